// *** bench/rgb_led_timing_tb_top.sv ***
`timescale 1ns/10ps
module rgb_led_timing_tb_top;
  import rgb_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic core_clk, nrst, ce;
  logic [ADDR_W-1:0] awAddr, arAddr;
  logic awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic [2:0] ledPin;
  int error_cnt = 0;
  int compares = 0;
  int hiCnt [3];

  rgb_led_timing dut (
    .core_clk(core_clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .ledPin(ledPin)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude;
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // Write: address and data offered together, each dropped once taken
  task automatic wrchk(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er, input string n);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wStrb <= s;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
      if (bValid === 1'b1) begin
        done = 1'b1;
        bReady <= 1'b0;
        chk(n, {30'h0, er}, {30'h0, bResp});
      end
    end
  endtask : wrchk

  // Read: response data taken at the edge where rvalid is seen
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er,
                       input string n);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      if (rValid === 1'b1) begin
        done = 1'b1;
        rReady <= 1'b0;
        chk(n, e, rData);
        chk(n, {30'h0, er}, {30'h0, rResp});
      end
    end
  endtask : rdchk

  // Count high cycles per pin; periodic waveform makes this phase independent
  task automatic meas(input int n);
    hiCnt = '{0, 0, 0};
    repeat (n) begin
      @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
        if (ledPin[i] === 1'b1) hiCnt[i]++;
      end
    end
  endtask : meas

  task automatic ledchk(input string n, input int er, input int eg, input int eb);
    chk(n, 32'(er), 32'(hiCnt[0]));
    chk(n, 32'(eg), 32'(hiCnt[1]));
    chk(n, 32'(eb), 32'(hiCnt[2]));
  endtask : ledchk

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far above the roughly 8.4k cycles the tests need
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    {awAddr, arAddr, wData, wStrb} = '0;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk("led_reset", 32'h7, {29'h0, ledPin});
    rdchk(BA_RED, 32'h0, RESP_OKAY, "red_rst");
    rdchk(BA_GRN, 32'h0, RESP_OKAY, "grn_rst");
    rdchk(BA_BLU, 32'h0, RESP_OKAY, "blu_rst");
    rdchk(BA_SLOPE, 32'h0, RESP_OKAY, "slope_rst");
    // Unused bits must read back zero
    wrchk(BA_RED, 32'hffff_ffff, 4'hf, RESP_OKAY, "red_wr");
    rdchk(BA_RED, 32'h7f7f, RESP_OKAY, "red_mask");
    wrchk(BA_GRN, 32'hffff_ffff, 4'hf, RESP_OKAY, "grn_wr");
    rdchk(BA_GRN, 32'h7f7f, RESP_OKAY, "grn_mask");
    wrchk(BA_SLOPE, 32'hffff_ffff, 4'hf, RESP_OKAY, "slope_wr");
    rdchk(BA_SLOPE, 32'h7fff, RESP_OKAY, "slope_mask");
    // Byte lane write only touches the on field
    wrchk(BA_BLU, 32'h0605, 4'hf, RESP_OKAY, "blu_wr");
    wrchk(BA_BLU, 32'h7f7f, 4'h1, RESP_OKAY, "blu_lane");
    rdchk(BA_BLU, 32'h067f, RESP_OKAY, "blu_lane_rd");
    wrchk(BA_BLU, 32'h0605, 4'hf, RESP_OKAY, "blu_wr2");
    // Unmapped word
    wrchk(16'hd004, 32'h1234, 4'hf, RESP_SLVERR, "unmap_wr");
    rdchk(16'hd004, 32'h0, RESP_SLVERR, "unmap_rd");
    // Windows: red 10..19, green whole cycle, blue 5..6
    wrchk(BA_RED, 32'h130a, 4'hf, RESP_OKAY, "red_set");
    wrchk(BA_GRN, 32'h7f00, 4'hf, RESP_OKAY, "grn_set");
    wrchk(BA_SLOPE, 32'h0, 4'hf, RESP_OKAY, "slope_set");
    wrchk(BA_DUTY, 32'h0fff, 4'hf, RESP_OKAY, "duty_set");
    wrchk(BA_DIV, 32'h0, 4'hf, RESP_OKAY, "div_set");
    wrchk(BA_CTRL, 32'h6, 4'hf, RESP_OKAY, "ctrl_on");
    repeat (300) @(posedge core_clk);
    meas(128);
    ledchk("win_1to1", 10, 128, 2);
    // Clock enable low freezes every pin at the level it had
    ce <= 1'b0;
    meas(64);
    ce <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      chk("ce_freeze", 32'h1, 32'(hiCnt[i] == 0 || hiCnt[i] == 64));
    end
    // Halved pulse clock doubles every on time
    wrchk(BA_DIV, 32'h1, 4'hf, RESP_OKAY, "div2");
    repeat (600) @(posedge core_clk);
    meas(256);
    ledchk("win_2to1", 20, 256, 4);
    // Inverted polarity
    wrchk(BA_DIV, 32'h0, 4'hf, RESP_OKAY, "div1");
    wrchk(BA_CTRL, 32'h2, 4'hf, RESP_OKAY, "ctrl_inv");
    repeat (300) @(posedge core_clk);
    meas(128);
    ledchk("win_inv", 118, 0, 126);
    // Disabled outputs held high
    wrchk(BA_CTRL, 32'h0, 4'hf, RESP_OKAY, "ctrl_off");
    meas(128);
    ledchk("disabled", 128, 128, 128);
    // Green max of 7 gives 8 sixteenths with zero slope
    wrchk(BA_DUTY, 32'h0f7f, 4'hf, RESP_OKAY, "duty_g7");
    wrchk(BA_CTRL, 32'h6, 4'hf, RESP_OKAY, "ctrl_on2");
    repeat (300) @(posedge core_clk);
    meas(128);
    chk("grn_half", 32'd64, 32'(hiCnt[1]));
    // Green slope 1 every cycle: starts dim, full after 16 cycles
    wrchk(BA_CTRL, 32'h0, 4'hf, RESP_OKAY, "ctrl_off2");
    wrchk(BA_DUTY, 32'h0fff, 4'hf, RESP_OKAY, "duty_full");
    wrchk(BA_SLOPE, 32'h0010, 4'hf, RESP_OKAY, "slope_g1");
    wrchk(BA_CTRL, 32'h6, 4'hf, RESP_OKAY, "ctrl_on3");
    meas(128);
    chk("ramp_early", 32'h1, 32'(hiCnt[1] < 64));
    repeat (2600) @(posedge core_clk);
    meas(128);
    chk("ramp_full", 32'd128, 32'(hiCnt[1]));
    // Lowering green maximum after the ramp is full caps it at 8 sixteenths
    wrchk(BA_DUTY, 32'h0f7f, 4'hf, RESP_OKAY, "duty_low");
    repeat (4) @(posedge core_clk);
    meas(128);
    chk("ramp_lowered", 32'd64, 32'(hiCnt[1]));
    // Pulse counter 7 slows the ramp eightfold
    wrchk(BA_CTRL, 32'h0, 4'hf, RESP_OKAY, "ctrl_off3");
    wrchk(BA_SLOPE, 32'h7010, 4'hf, RESP_OKAY, "slope_m7");
    wrchk(BA_CTRL, 32'h6, 4'hf, RESP_OKAY, "ctrl_on4");
    repeat (2600) @(posedge core_clk);
    meas(128);
    chk("ramp_slow", 32'h1, 32'(hiCnt[1] < 64));
    // Divide select above 8 stops the pulse clock, so no window ever opens
    wrchk(BA_CTRL, 32'h0, 4'hf, RESP_OKAY, "ctrl_off4");
    wrchk(BA_DIV, 32'h9, 4'hf, RESP_OKAY, "div_stop_wr");
    wrchk(BA_STAT, 32'hffff, 4'hf, RESP_OKAY, "stat_wr");
    wrchk(BA_CTRL, 32'h6, 4'hf, RESP_OKAY, "ctrl_on5");
    meas(128);
    ledchk("div_stop", 0, 0, 0);
    rdchk(BA_STAT, 32'h0, RESP_OKAY, "stat_rd");
    conclude();
  end
endmodule : rgb_led_timing_tb_top

// *** hw/rgb_led_chan.sv ***
`timescale 1ns/10ps
module rgb_led_chan (
  // Clock and control
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  // Pulse timebase
  input wire logic tick,
  input wire logic [rgb_pkg::PT_W-1:0] pos,
  input wire logic [rgb_pkg::NIB_W-1:0] sub,
  // Settings
  input wire logic [rgb_pkg::PT_W-1:0] onPt,
  input wire logic [rgb_pkg::PT_W-1:0] offPt,
  input wire logic [rgb_pkg::NIB_W-1:0] slope,
  input wire logic [rgb_pkg::M_W-1:0] stepM,
  input wire logic [rgb_pkg::NIB_W-1:0] maxDuty,
  // Results
  output logic lit,
  output logic pwmOut
);
  import rgb_pkg::*;

  typedef struct packed {
    logic [RAMP_W-1:0] ramp;
    logic [M_W-1:0] stepCnt;
    logic lit;
    logic pwm;
  } rgb_chan_t;

  rgb_chan_t st_r;
  rgb_chan_t st_nxt;
  logic [PT_W:0] offEnd;
  logic [RAMP_W-1:0] target;
  logic [RAMP_W:0] rampSum;
  logic inWin;

  ////////////////////////////////////////////////////////////////////////////
  // Window and ramp arithmetic
  assign offEnd = {1'b0, offPt} + {{PT_W{1'b0}}, 1'b1}; // Off time is field plus one
  assign inWin = (pos >= onPt) && ({1'b0, pos} < offEnd);
  assign target = {1'b0, maxDuty} + {{(RAMP_W-1){1'b0}}, 1'b1};
  assign rampSum = {1'b0, st_r.ramp} + {{(RAMP_W-NIB_W+1){1'b0}}, slope};

  // Next state; the ramp rises by slope steps but falls to a lowered maximum, it is cleared when the colour stops
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt = '0;
    end else begin
      if (tick) begin
        st_nxt.lit = inWin;
      end
      if (slope == '0) begin
        st_nxt.ramp = target; // Zero slope jumps to the maximum duty
        st_nxt.stepCnt = '0;
      end else if (tick && pos == PT_FULL) begin
        // Step once per M+1 whole pulse cycles
        if (st_r.stepCnt == stepM) begin
          st_nxt.stepCnt = '0;
          st_nxt.ramp = (rampSum > {1'b0, target}) ? target : rampSum[RAMP_W-1:0];
        end else begin
          st_nxt.stepCnt = st_r.stepCnt + {{(M_W-1){1'b0}}, 1'b1};
        end
      end
      // A lowered maximum pulls a running ramp down at once, so duty never exceeds it
      if (st_nxt.ramp > target) begin
        st_nxt.ramp = target;
      end
      st_nxt.pwm = st_nxt.lit && ({1'b0, sub} < st_nxt.ramp);
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign lit = st_r.lit;
  assign pwmOut = st_r.pwm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_turn_on;
    @(posedge core_clk) disable iff (!nrst)
      (ce && run && tick && pos == onPt && onPt < offPt) |=> lit;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("LED missed on point");

  property p_turn_off;
    @(posedge core_clk) disable iff (!nrst)
      (ce && run && tick && offPt != PT_FULL && {1'b0, pos} == offEnd) |=> !lit;
  endproperty
  a_turn_off: assert property (p_turn_off) else $error("LED missed off point");

  property p_full_on;
    @(posedge core_clk) disable iff (!nrst)
      (ce && run && tick && offPt == PT_FULL && pos >= onPt) |=> lit;
  endproperty
  a_full_on: assert property (p_full_on) else $error("Full-on LED went dark");

  property p_slope_zero;
    @(posedge core_clk) disable iff (!nrst)
      (ce && run && slope == '0) |=> (st_r.ramp == $past(target));
  endproperty
  a_slope_zero: assert property (p_slope_zero) else $error("Zero slope not at max");

  property p_ramp_cap;
    @(posedge core_clk) disable iff (!nrst)
      (ce && $stable(maxDuty)) |=> (st_r.ramp <= $past(target));
  endproperty
  a_ramp_cap: assert property (p_ramp_cap) else $error("Ramp above maximum duty");
endmodule : rgb_led_chan

// *** hw/rgb_led_timing.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module rgb_led_timing (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [rgb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [rgb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // LED pins, red green blue
  output logic [2:0] ledPin
);
  import rgb_pkg::*;

  typedef struct packed {
    rgb_bus_t phase;
    logic awGot;
    logic wGot;
    logic [ADDR_W-1:0] awAddr;
    logic [15:0] wData;
    logic [1:0] wStrb;
    logic [31:0] rData;
    logic [1:0] resp;
    logic [15:0] ctrl;
    logic [15:0] div;
    logic [2:0][15:0] onOff;
    logic [15:0] slope;
    logic [15:0] duty;
    logic [3:0] divCnt;
    logic tick;
    logic [PT_W-1:0] pos;
    logic [NIB_W-1:0] sub;
    logic [2:0] pins;
  } rgb_top_t;

  rgb_top_t st_r;
  rgb_top_t st_nxt;
  logic awHs;
  logic wHs;
  logic arHs;
  logic run;
  logic pol;
  logic [3:0] divLim;
  logic [2:0] chLit;
  logic [2:0] chPwm;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes; a read waits while any write is pending so one at a time
  assign awHs = s_axi_awvalid && s_axi_awready;
  assign wHs = s_axi_wvalid && s_axi_wready;
  assign arHs = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = ce && st_r.phase == BUS_IDLE && !st_r.awGot;
  assign s_axi_wready = ce && st_r.phase == BUS_IDLE && !st_r.wGot;
  assign s_axi_arready = ce && st_r.phase == BUS_IDLE && !st_r.awGot && !st_r.wGot
    && !s_axi_awvalid && !s_axi_wvalid;
  assign s_axi_bvalid = st_r.phase == BUS_WRESP;
  assign s_axi_rvalid = st_r.phase == BUS_RRESP;
  assign s_axi_bresp = st_r.resp;
  assign s_axi_rresp = st_r.resp;
  assign s_axi_rdata = st_r.rData;
  assign ledPin = st_r.pins;

  assign run = st_r.ctrl[CTRL_EN_BIT];
  assign pol = st_r.ctrl[CTRL_POL_BIT];
  // Divide ratio 1, then 2*sel; limit is ratio minus one
  assign divLim = (st_r.div[3:0] == DIV_ONE) ? DIV_ONE : 4'((st_r.div[3:0] << 1) - 4'h1);

  // Byte-lane merge of the low two lanes; upper lanes hold nothing
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
                                        input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) v[7:0] = dat[7:0];
    if (strb[1]) v[15:8] = dat[15:8];
    merge = v & mask;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    if (awHs) begin
      st_nxt.awGot = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (wHs) begin
      st_nxt.wGot = 1'b1;
      st_nxt.wData = s_axi_wdata[15:0];
      st_nxt.wStrb = s_axi_wstrb[1:0];
    end
    case (st_r.phase)
      BUS_IDLE: begin
        if (st_r.awGot && st_r.wGot) begin
          st_nxt.awGot = 1'b0;
          st_nxt.wGot = 1'b0;
          st_nxt.phase = BUS_WRESP;
          st_nxt.resp = RESP_OKAY;
          // Unused bits are dropped on write so they read back zero
          case (st_r.awAddr)
            BA_CTRL: st_nxt.ctrl = merge(st_r.ctrl, st_r.wData, st_r.wStrb, CTRL_MASK);
            BA_DIV: st_nxt.div = merge(st_r.div, st_r.wData, st_r.wStrb, DIV_MASK);
            BA_RED: st_nxt.onOff[0] = merge(st_r.onOff[0], st_r.wData, st_r.wStrb, ONOFF_MASK);
            BA_GRN: st_nxt.onOff[1] = merge(st_r.onOff[1], st_r.wData, st_r.wStrb, ONOFF_MASK);
            BA_BLU: st_nxt.onOff[2] = merge(st_r.onOff[2], st_r.wData, st_r.wStrb, ONOFF_MASK);
            BA_SLOPE: st_nxt.slope = merge(st_r.slope, st_r.wData, st_r.wStrb, SLOPE_MASK);
            BA_DUTY: st_nxt.duty = merge(st_r.duty, st_r.wData, st_r.wStrb, DUTY_MASK);
            BA_STAT: st_nxt.resp = RESP_OKAY; // Read-only, write ignored
            default: st_nxt.resp = RESP_SLVERR;
          endcase
        end else if (arHs) begin
          st_nxt.phase = BUS_RRESP;
          st_nxt.resp = RESP_OKAY;
          st_nxt.rData = '0;
          case (s_axi_araddr)
            BA_CTRL: st_nxt.rData[15:0] = st_r.ctrl;
            BA_DIV: st_nxt.rData[15:0] = st_r.div;
            BA_RED: st_nxt.rData[15:0] = st_r.onOff[0];
            BA_GRN: st_nxt.rData[15:0] = st_r.onOff[1];
            BA_BLU: st_nxt.rData[15:0] = st_r.onOff[2];
            BA_SLOPE: st_nxt.rData[15:0] = st_r.slope;
            BA_DUTY: st_nxt.rData[15:0] = st_r.duty;
            BA_STAT: st_nxt.rData[15:0] = {5'h00, chLit, 1'b0, st_r.pos};
            default: st_nxt.resp = RESP_SLVERR;
          endcase
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) st_nxt.phase = BUS_IDLE;
      end
      BUS_RRESP: begin
        if (s_axi_rready) st_nxt.phase = BUS_IDLE;
      end
      default: st_nxt.phase = BUS_IDLE;
    endcase

    // Pulse clock; a stopped divider also freezes the 128-step cycle
    st_nxt.tick = 1'b0;
    if (!run || st_r.div[3:0] > DIV_MAX) begin
      st_nxt.divCnt = '0;
    end else if (st_r.divCnt >= divLim) begin
      st_nxt.divCnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.divCnt = st_r.divCnt + 4'h1;
    end

    // Cycle position restarts at zero each 128 steps
    if (!run) begin
      st_nxt.pos = PT_ZERO;
      st_nxt.sub = '0;
    end else if (st_r.tick) begin
      st_nxt.pos = st_r.pos + 7'h01;
      st_nxt.sub = st_r.sub + 4'h1;
    end

    // Disabled pins hold high; polarity low inverts the driven level
    for (int i = 0; i < 3; i++) begin
      st_nxt.pins[i] = run ? (pol ? chPwm[i] : !chPwm[i]) : 1'b1;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.pins <= 3'h7;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One timing channel per colour
  generate
    for (genvar c = 0; c < 3; c++) begin : g_chan
      rgb_led_chan u_chan (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .run(run),
        .tick(st_r.tick),
        .pos(st_r.pos),
        .sub(st_r.sub),
        .onPt(st_r.onOff[c][ON_LSB +: PT_W]),
        .offPt(st_r.onOff[c][OFF_LSB +: PT_W]),
        .slope(st_r.slope[c*NIB_W +: NIB_W]),
        .stepM(st_r.slope[M_LSB +: M_W]),
        .maxDuty(st_r.duty[c*NIB_W +: NIB_W]),
        .lit(chLit[c]),
        .pwmOut(chPwm[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_unused_zero;
    @(posedge core_clk) disable iff (!nrst)
      ((st_r.onOff[0] | st_r.onOff[1] | st_r.onOff[2]) & ~ONOFF_MASK) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("On/off unused bit set");

  property p_pos_wrap;
    @(posedge core_clk) disable iff (!nrst)
      (ce && run && st_r.tick && st_r.pos == PT_FULL) |=> (st_r.pos == PT_ZERO);
  endproperty
  a_pos_wrap: assert property (p_pos_wrap) else $error("Pulse cycle not 128 steps");
endmodule : rgb_led_timing

// *** hw/rgb_pkg.sv ***
package rgb_pkg;
  // Register indices; byte address is four times the index
  localparam int ADDR_W = 16;
  localparam logic [15:0] IDX_CTRL = 16'h3400;
  localparam logic [15:0] IDX_DIV = 16'h3402;
  localparam logic [15:0] IDX_RED = 16'h3404;
  localparam logic [15:0] IDX_GRN = 16'h3406;
  localparam logic [15:0] IDX_BLU = 16'h3408;
  localparam logic [15:0] IDX_SLOPE = 16'h340a;
  localparam logic [15:0] IDX_DUTY = 16'h340c;
  localparam logic [15:0] IDX_STAT = 16'h3414;
  localparam logic [ADDR_W-1:0] BA_CTRL = ADDR_W'(IDX_CTRL * 4);
  localparam logic [ADDR_W-1:0] BA_DIV = ADDR_W'(IDX_DIV * 4);
  localparam logic [ADDR_W-1:0] BA_RED = ADDR_W'(IDX_RED * 4);
  localparam logic [ADDR_W-1:0] BA_GRN = ADDR_W'(IDX_GRN * 4);
  localparam logic [ADDR_W-1:0] BA_BLU = ADDR_W'(IDX_BLU * 4);
  localparam logic [ADDR_W-1:0] BA_SLOPE = ADDR_W'(IDX_SLOPE * 4);
  localparam logic [ADDR_W-1:0] BA_DUTY = ADDR_W'(IDX_DUTY * 4);
  localparam logic [ADDR_W-1:0] BA_STAT = ADDR_W'(IDX_STAT * 4);
  // Field layout
  localparam int PT_W = 7;
  localparam int ON_LSB = 0;
  localparam int OFF_LSB = 8;
  localparam logic [15:0] ONOFF_MASK = 16'h7f7f;
  localparam logic [15:0] SLOPE_MASK = 16'h7fff;
  localparam logic [15:0] DUTY_MASK = 16'h0fff;
  localparam logic [15:0] DIV_MASK = 16'h000f;
  localparam logic [15:0] CTRL_MASK = 16'h0006;
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int NIB_W = 4;
  localparam int M_LSB = 12;
  localparam int M_W = 3;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [PT_W-1:0] PT_FULL = 7'h7f;
  localparam logic [PT_W-1:0] PT_ZERO = 7'h00;
  localparam int RAMP_W = 5;
  // Clock divider: selects above DIV_MAX stop the pulse clock
  localparam logic [3:0] DIV_MAX = 4'h8;
  localparam logic [3:0] DIV_ONE = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRESP, BUS_RRESP} rgb_bus_t;
endpackage : rgb_pkg
